// *** edge_det.sv ***
// Rising and falling edge detector for a synchronous input
`default_nettype none
module edge_det (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic din,
  output logic      rise,
  output logic      fall
);
  logic prev_r;

  // Previous sample
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      prev_r <= 1'b0;
    else
      prev_r <= din;
  end

  assign rise = din & ~prev_r;
  assign fall = ~din & prev_r;
endmodule
`default_nettype wire

// *** step_dir_microstep_driver_ctrl.sv ***
// Step/direction microstep controller with protection and current setpoint
`default_nettype none
module step_dir_microstep_driver_ctrl
  import stepdrv_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = stepdrv_pkg::IDLE_CYC
) (
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  input  wire logic                    step_in,
  input  wire logic                    dir_in,
  input  wire logic                    res_sel,
  input  wire logic                    enable_in,
  input  wire logic                    boost_in,
  input  wire logic [7:0]              temp_deg,
  input  wire logic [9:0]              vsup_dv,
  output logic [stepdrv_pkg::POS_W-1:0] position,
  output logic                         fine_res,
  output logic                         drv_on,
  output logic                         standstill,
  output logic [7:0]                   cur_set,
  output logic                         temp_fault,
  output logic                         volt_fault
);
  import stepdrv_pkg::*;

  drv_state_t        state_r, state_nxt;
  logic [POS_W-1:0]  pos_r, pos_nxt;
  logic              res_r;
  logic              tf_r, vf_r;
  logic [31:0]       idle_r;
  logic              still_r;
  logic [7:0]        cur_r, cur_nxt;
  logic              step_rise, en_rise;
  logic              temp_hot, temp_cool, v_bad, v_good, fault_any;
  logic              running;
  logic [POS_W-1:0]  inc, pos_fwd, pos_rev;
  logic [7:0]        base_cur, cur_run;

  // Step pulse edge: only the rise is used
  edge_det u_step (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (step_in),
    .rise    (step_rise),
    .fall    ()
  );

  // Enable edge for restart after a protective shutdown
  edge_det u_en (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (enable_in),
    .rise    (en_rise),
    .fall    ()
  );

  // Protection thresholds with hysteresis
  // trip points
  assign temp_hot  = temp_deg > TEMP_LIMIT;
  assign v_bad     = (vsup_dv < VSUP_MIN) || (vsup_dv > VSUP_MAX);
  assign temp_cool = temp_deg <= (TEMP_LIMIT - TEMP_HYST);
  assign v_good    = (vsup_dv >= (VSUP_MIN + VSUP_HYST))
                  && (vsup_dv <= (VSUP_MAX - VSUP_HYST));
  assign fault_any = tf_r | vf_r | temp_hot | v_bad;

  // Fault flags: set wins, clear only past hysteresis
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tf_r <= 1'b0;
      vf_r <= 1'b0;
    end
    else
    begin
      tf_r <= temp_hot | (tf_r & ~temp_cool);
      vf_r <= v_bad | (vf_r & ~v_good);
    end
  end

  // Driver state machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF:
        if (fault_any)
          state_nxt = ST_FAULT;
        else if (enable_in)
          state_nxt = ST_RUN;
      ST_RUN:
        if (fault_any)
          state_nxt = ST_FAULT;
        else if (!enable_in)
          state_nxt = ST_OFF;
      ST_FAULT:
        if (!fault_any && en_rise)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  assign running = (state_r == ST_RUN);

  // Resolution latch
  // follow input only while disabled
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      res_r <= 1'b0;
    else if (!enable_in && !running)
      res_r <= res_sel;
  end

  // Position arithmetic, wraps at one revolution
  // step size by resolution
  assign inc     = res_r ? INC_FINE : INC_COARSE;
  assign pos_fwd = (pos_r >= POS_PER_REV - inc) ?
                   POS_W'(pos_r + inc - POS_PER_REV) : POS_W'(pos_r + inc);
  assign pos_rev = (pos_r < inc) ?
                   POS_W'(pos_r + POS_PER_REV - inc) : POS_W'(pos_r - inc);
  // one increment per rise (INC_FINE or INC_COARSE), direction picks sign
  assign pos_nxt = (running && step_rise) ?
                   (dir_in ? pos_rev : pos_fwd) : pos_r;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pos_r <= POS_RST;
    else
      pos_r <= pos_nxt;
  end

  // Standstill timer; 32 bits covers any sane timeout
  // idle timeout and exit on step
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      idle_r  <= 32'h0000_0000;
      still_r <= 1'b1;
    end
    else if (step_rise)
    begin
      idle_r  <= 32'h0000_0000;
      still_r <= 1'b0;
    end
    else if (idle_r >= IDLE_CYCLES - 1)
      still_r <= 1'b1;
    else
      idle_r  <= idle_r + 32'h0000_0001;
  end

  // Current setpoint
  // boost level
  assign base_cur = boost_in ? CUR_BOOST : CUR_NOMINAL;
  assign cur_run  = still_r ? 8'((16'(base_cur) * 16'h0002) / 16'h0003)
                            : base_cur;
  assign cur_nxt  = running ? cur_run : CUR_OFF;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      cur_r <= CUR_OFF;
    else
      cur_r <= cur_nxt;
  end

  assign position   = pos_r;
  assign fine_res   = res_r;
  assign drv_on     = running;
  assign standstill = still_r;
  assign cur_set    = cur_r;
  assign temp_fault = tf_r;
  assign volt_fault = vf_r;

  // Checks
  // step advances position
  step_moves_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    running && step_rise && !fault_any |=> position != $past(position))
    else $error("step did not move position");
  no_motion_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !step_rise |=> position == $past(position))
    else $error("position moved without step");
  res_frozen_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    enable_in |=> fine_res == $past(fine_res))
    else $error("resolution changed while enabled");
  temp_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    temp_hot |=> !drv_on ##1 cur_set == CUR_OFF)
    else $error("driver stayed on when hot");
  volt_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    v_bad |=> !drv_on)
    else $error("driver stayed on with bad supply");
  restart_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    state_r == ST_FAULT && !en_rise |=> !drv_on)
    else $error("restart without enable edge");
  temp_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    temp_fault && !temp_cool |=> temp_fault)
    else $error("temperature fault cleared early");
  boost_cur_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    running && boost_in && !still_r && !fault_any && enable_in
    |=> cur_set == CUR_BOOST)
    else $error("boost current not applied");
  still_cur_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    running && still_r && !boost_in && enable_in && !fault_any
    |=> cur_set == 8'h80)
    else $error("standstill current not reduced");
  still_exit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    step_rise |=> !standstill)
    else $error("standstill not left on step");

  run_step_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    running && step_rise);
  fault_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_r == ST_FAULT ##[1:1000] drv_on);
  still_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    running && $rose(standstill));
endmodule
`default_nettype wire

// *** stepdrv_ctl_model.sv ***
// Motion controller model driving the step, direction and mode inputs
`default_nettype none
module stepdrv_ctl_model #(
  parameter int unsigned HALF = 250
) (
  input  wire logic clk_sys,
  output var logic  step_in,
  output var logic  dir_in,
  output var logic  res_sel,
  output var logic  enable_in,
  output var logic  boost_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // All control lines idle low from time zero
  initial
  begin
    step_in = 1'b0;
    dir_in = 1'b0;
    res_sel = 1'b0;
    enable_in = 1'b0;
    boost_in = 1'b0;
  end
  // pulse period kept at 200 kHz
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_sys) step_in <= ~step_in;
      repeat (HALF) @(posedge clk_sys);
      step_in <= ~step_in;
      repeat (HALF) @(posedge clk_sys);
    end
  endtask
  // resolution changed only while disabled, unless told to misbehave
  task automatic set_res(input logic v, input bit rude);
    @(posedge clk_sys);
    if (!enable_in || rude)
      res_sel <= v;
  endtask
  // enable level, pulsed low then high to restart
  task automatic set_en(input logic v);
    @(posedge clk_sys) enable_in <= v;
  endtask
  task automatic set_lvl(input logic d, input logic b);
    @(posedge clk_sys);
    dir_in <= d;
    boost_in <= b;
  endtask
endmodule
`default_nettype wire

// *** stepdrv_pkg.sv ***
// Shared constants and types for the step/direction microstep controller
`default_nettype none
package stepdrv_pkg;
  // Clock and standstill timing
  localparam int unsigned CLK_HZ          = 100000000;
  localparam int unsigned IDLE_MS         = 100;
  localparam int unsigned IDLE_CYC        = IDLE_MS * (CLK_HZ / 1000);
  // Microstep position: 256 microsteps per full step, 200 full steps
  localparam int unsigned POS_W           = 16;
  localparam logic [15:0] POS_PER_REV     = 16'hC800; // 51200
  localparam logic [15:0] POS_RST         = 16'h0000;
  // Increment per pulse in 1/256 units
  localparam logic [15:0] INC_FINE        = 16'h0001;
  localparam logic [15:0] INC_COARSE      = 16'h0020; // 1/8 step
  // Current setpoint codes, full scale 8'hFF
  localparam logic [7:0]  CUR_NOMINAL     = 8'hC0;
  localparam logic [7:0]  CUR_BOOST       = 8'hFF;
  localparam logic [7:0]  CUR_OFF         = 8'h00;
  // Hysteresis: temperature in deg C, supply in 0.1 V units
  localparam logic [7:0]  TEMP_LIMIT      = 8'h64; // 100 C
  localparam logic [7:0]  TEMP_HYST       = 8'h0A; // 10 C
  localparam logic [9:0]  VSUP_MIN        = 10'h0C0; // 19.2 V
  localparam logic [9:0]  VSUP_MAX        = 10'h120; // 28.8 V
  localparam logic [9:0]  VSUP_HYST       = 10'h00A; // 1 V
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_FAULT} drv_state_t;
endpackage
`default_nettype wire

// *** tb_step_dir_microstep_driver_ctrl.sv ***
// Self-checking bench for the step/direction microstep controller
`default_nettype none
module tb_step_dir_microstep_driver_ctrl;
  import stepdrv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned IDLE = 600; // Longer than one step period
  logic        clk_sys, resetn, step_in, dir_in, res_sel, enable_in, boost_in;
  logic        fine_res, drv_on, standstill, temp_fault, volt_fault;
  logic [7:0]  temp_deg, cur_set;
  logic [9:0]  vsup_dv;
  logic [15:0] position, flags, cur16;
  int          n_mismatch, total_checks;
  // Bits: fine, on, standstill, temp fault, supply fault
  assign flags = {11'h000, fine_res, drv_on, standstill, temp_fault,
                  volt_fault};
  assign cur16 = {8'h00, cur_set};
  step_dir_microstep_driver_ctrl #(.IDLE_CYCLES(IDLE))
    step_dir_microstep_driver_ctrl_i (.clk_sys(clk_sys), .resetn(resetn),
    .step_in(step_in), .dir_in(dir_in), .res_sel(res_sel),
    .enable_in(enable_in), .boost_in(boost_in), .temp_deg(temp_deg),
    .vsup_dv(vsup_dv), .position(position), .fine_res(fine_res),
    .drv_on(drv_on), .standstill(standstill), .cur_set(cur_set),
    .temp_fault(temp_fault), .volt_fault(volt_fault));
  stepdrv_ctl_model stepdrv_ctl_model_i (.clk_sys(clk_sys),
    .step_in(step_in), .dir_in(dir_in), .res_sel(res_sel),
    .enable_in(enable_in), .boost_in(boost_in));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Masked compare, so unknown bits under the mask never match
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input logic [15:0] m = 16'hFFFF);
    total_checks++;
    if ((seen & m) !== (exp & m))
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Land past the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait on drv_on (which=0) or standstill (which=1)
  task automatic wait_sig(input bit which, input logic v, input int lim);
    int k = 0;
    while (((which ? standstill : drv_on) !== v) && k < lim)
    begin
      cyc(1);
      k++;
    end
    if ((which ? standstill : drv_on) !== v)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: wait ran out", $time);
      close_out();
    end
  endtask
  // Trip, stay latched inside hysteresis, clear, restart by enable edge
  task automatic trip(input logic [7:0] t0, t1, t2,
                      input logic [9:0] v0, v1, v2, input logic [1:0] f);
    @(posedge clk_sys);
    temp_deg <= t0;
    vsup_dv <= v0;
    cyc(1);
    chk(flags, {14'h0000, f}, 16'h000B);
    cyc(1);
    chk(cur16, 16'(CUR_OFF));
    @(posedge clk_sys);
    temp_deg <= t1;
    vsup_dv <= v1;
    cyc(3);
    chk(flags, {14'h0, f}, 16'h000B);
    @(posedge clk_sys);
    temp_deg <= t2;
    vsup_dv <= v2;
    cyc(3);
    chk(flags, 16'h0000, 16'h000B);
    stepdrv_ctl_model_i.set_en(1'b0);
    cyc(2);
    stepdrv_ctl_model_i.set_en(1'b1);
    wait_sig(1'b0, 1'b1, 4);
  endtask
  // Sweep temperature up or supply down one unit every two cycles past its limit
  task automatic ramp(input bit sup, input int n);
    logic hot, low;
    repeat (n)
    begin
      @(posedge clk_sys);
      if (sup)
        vsup_dv <= vsup_dv - 10'h001;
      else
        temp_deg <= temp_deg + 8'h01;
      cyc(1);
      hot = temp_deg > TEMP_LIMIT;
      low = vsup_dv < VSUP_MIN;
      chk(flags, {14'h0000, hot, low}, 16'h0003);
    end
  endtask
  initial
  begin
    n_mismatch = 0;
    total_checks = 0;
    resetn = 1'b0;
    temp_deg = 8'h19;
    vsup_dv = 10'h0F0;
    cyc(15);
    chk(flags, 16'h0004);
    chk(position, POS_RST);
    @(posedge clk_sys) resetn <= 1'b1;
    $display("test reset done");
    stepdrv_ctl_model_i.set_en(1'b1);
    wait_sig(1'b0, 1'b1, 4);
    cyc(2);
    chk(cur16, 16'(CUR_NOMINAL) * 16'h0002 / 16'h0003);
    stepdrv_ctl_model_i.pulse(3);
    cyc(1);
    chk(position, 16'(3 * INC_COARSE));
    chk(flags, 16'h0008, 16'h001C);
    chk(cur16, 16'(CUR_NOMINAL));
    stepdrv_ctl_model_i.set_lvl(1'b0, 1'b1);
    cyc(2);
    chk(cur16, 16'(CUR_BOOST));
    wait_sig(1'b1, 1'b1, IDLE + 10);
    cyc(2);
    chk(cur16, 16'(CUR_BOOST) * 16'h0002 / 16'h0003);
    stepdrv_ctl_model_i.set_lvl(1'b1, 1'b0);
    stepdrv_ctl_model_i.pulse(4);
    cyc(1);
    chk(position, POS_PER_REV - INC_COARSE);
    $display("test motion done");
    stepdrv_ctl_model_i.set_res(1'b1, 1'b1);
    cyc(3);
    chk(flags, 16'h0000, 16'h0010);
    stepdrv_ctl_model_i.set_en(1'b0);
    wait_sig(1'b0, 1'b0, 4);
    stepdrv_ctl_model_i.set_res(1'b1, 1'b0);
    cyc(2);
    chk(flags, 16'h0010, 16'h0010);
    stepdrv_ctl_model_i.set_lvl(1'b0, 1'b0);
    stepdrv_ctl_model_i.set_en(1'b1);
    wait_sig(1'b0, 1'b1, 4);
    stepdrv_ctl_model_i.pulse(1);
    cyc(1);
    chk(position, POS_PER_REV - INC_COARSE + INC_FINE);
    $display("test resolution done");
    @(posedge clk_sys) temp_deg <= 8'h60;
    ramp(1'b0, 8);
    trip(8'h65, 8'h5B, 8'h5A, 10'h0F0, 10'h0F0, 10'h0F0, 2'b10);
    @(posedge clk_sys) vsup_dv <= 10'h0C3;
    ramp(1'b1, 6);
    trip(8'h19, 8'h19, 8'h19, 10'h0BF, 10'h0C9, 10'h0CA, 2'b01);
    trip(8'h19, 8'h19, 8'h19, 10'h121, 10'h117, 10'h116, 2'b01);
    $display("test protection done");
    close_out();
  end
endmodule
`default_nettype wire
